// >>> verilog/dsp_exec.sv
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "dsp_exec_consts.svh"

module dsp_exec #(
    parameter int RPT_W = 8
) (
    input  wire logic             CLOCK,
    input  wire logic             RST,
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [7:0]       PADDR,
    input  wire logic [31:0]      PWDATA,
    output logic      [31:0]      PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    input  wire logic             INSTR_VALID,
    output logic                  INSTR_READY,
    input  wire logic [2:0]       INSTR_OP,
    input  wire logic [1:0]       INSTR_PTR_SEL,
    input  wire logic             INSTR_POSTINC,
    input  wire logic             INSTR_STEP2,
    input  wire logic [1:0]       INSTR_PREMOD,
    input  wire logic [RPT_W-1:0] INSTR_REPEAT,
    input  wire logic [15:0]      PC_IN,
    input  wire logic [15:0]      LOOP_START_PC,
    output logic      [15:0]      DMEM_ADDR,
    input  wire logic [15:0]      DMEM_RDATA,
    output logic      [15:0]      PMEM_ADDR,
    input  wire logic [15:0]      PMEM_RDATA,
    output logic                  PC_LOAD,
    output logic      [15:0]      PC_TARGET,
    output logic                  INSTR_DONE,
    output logic                  IRQ_HOLD,
    output logic                  IRQ_RELEASE
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dsp_exec_pkg::corr_state_t state_r;
    logic [15:0]      acc_r [16];
    logic [3:0]       acc_ptr_r [4];
    logic [15:0]      loop_count_reg_r;
    logic [15:0]      circular_step_reg_r;
    logic [15:0]      ptr_even_r;
    logic [15:0]      ptr_odd_r;
    logic             tag_r;
    logic             sign_flag_r;
    logic             carry_flag_r;
    logic             zero_flag_r;
    logic             loop_hold_r;
    logic [RPT_W:0]   taps_left_r;
    logic [RPT_W:0]   taps_r;
    logic             postinc_r;
    logic [3:0]       corr_acc_r;
    logic [31:0]      product_r;
    logic [47:0]      sum_r;
    logic [47:0]      sum_nxt;
    logic [3:0]       fill_ptr_nxt;
    logic             take;
    logic             apb_wr;
    logic             apb_setup;
    logic             corr_last;
    dsp_exec_pkg::op_t op;

    function automatic logic [3:0] premod(input logic [3:0] p, input logic [1:0] m);
        logic [3:0] r;
        r = p;
        if (m == dsp_exec_pkg::PM_INC) begin
            r = p + 4'h1;
        end else if (m == dsp_exec_pkg::PM_DEC) begin
            r = p - 4'h1;
        end
        return r;
    endfunction : premod

    assign op           = dsp_exec_pkg::op_t'(INSTR_OP);
    assign INSTR_READY  = (state_r == dsp_exec_pkg::ST_IDLE);
    assign take         = INSTR_VALID && INSTR_READY;
    assign apb_setup    = PSEL && !PENABLE;
    assign apb_wr       = PSEL && PENABLE && PWRITE;
    assign corr_last    = (state_r == dsp_exec_pkg::ST_ACC) && (taps_left_r == {{RPT_W{1'b0}}, 1'b1});
    assign sum_nxt      = sum_r + {{16{product_r[31]}}, product_r};                                // RQ1
    assign fill_ptr_nxt = premod(acc_ptr_r[INSTR_PTR_SEL], INSTR_PREMOD);                        // RQ13
    assign DMEM_ADDR    = ptr_even_r;
    assign PMEM_ADDR    = ptr_odd_r;                                                              // RQ3
    // Held from the accepting edge on, so nothing slips in at the start.
    assign IRQ_HOLD     = (state_r != dsp_exec_pkg::ST_IDLE) || loop_hold_r;                      // RQ5 RQ18
    assign PREADY       = 1'b1;

    // ------------------------------------------------------------
    // Correlation sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_r     <= dsp_exec_pkg::ST_IDLE;
            taps_left_r <= '0;
            taps_r      <= '0;
            postinc_r   <= 1'b0;
            corr_acc_r  <= 4'h0;
            product_r   <= 32'h0000_0000;
            sum_r       <= 48'h0000_0000_0000;
        end else begin
            unique case (state_r)
                dsp_exec_pkg::ST_IDLE: begin
                    if (take && op == dsp_exec_pkg::OP_CORRELATE) begin
                        taps_left_r <= {1'b0, INSTR_REPEAT} + (RPT_W+1)'(`TAP_EXTRA);          // RQ18
                        taps_r      <= {1'b0, INSTR_REPEAT} + (RPT_W+1)'(`TAP_EXTRA);
                        postinc_r   <= INSTR_POSTINC;
                        corr_acc_r  <= acc_ptr_r[INSTR_PTR_SEL];
                        sum_r       <= 48'h0000_0000_0000;
                        state_r     <= dsp_exec_pkg::ST_ADDR;
                    end
                end
                dsp_exec_pkg::ST_ADDR: begin
                    state_r <= dsp_exec_pkg::ST_MULT;                                            // RQ2
                end
                dsp_exec_pkg::ST_MULT: begin
                    product_r <= 32'($signed(DMEM_RDATA) * $signed(PMEM_RDATA));                 // RQ1
                    state_r   <= dsp_exec_pkg::ST_ACC;
                end
                dsp_exec_pkg::ST_ACC: begin
                    sum_r       <= sum_nxt;
                    taps_left_r <= taps_left_r - (RPT_W+1)'(1);
                    state_r     <= corr_last ? dsp_exec_pkg::ST_IDLE : dsp_exec_pkg::ST_ADDR;    // RQ2
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address pointers and loop registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ptr_even_r          <= `RST_WORD;
            ptr_odd_r           <= `RST_WORD;
            circular_step_reg_r <= `RST_WORD;
            loop_count_reg_r    <= `RST_WORD;
            tag_r               <= 1'b0;
        end else begin
            if (state_r == dsp_exec_pkg::ST_ACC) begin
                ptr_odd_r <= ptr_odd_r + 16'h0001;
                if (tag_r) begin
                    ptr_even_r <= ptr_even_r + circular_step_reg_r;                              // RQ6
                end else if (postinc_r) begin
                    ptr_even_r <= ptr_even_r + 16'h0001;                                         // RQ6
                end
            end else if (apb_wr && PADDR == `OFS_PTR_EVEN) begin
                ptr_even_r <= PWDATA[15:0];
            end else if (apb_wr && PADDR == `OFS_PTR_ODD) begin
                ptr_odd_r <= PWDATA[15:0];
            end
            // The loop count update from the instruction stream beats a software write.
            if (take && op == dsp_exec_pkg::OP_LOOP_CLOSE && !loop_count_reg_r[15]) begin
                loop_count_reg_r <= loop_count_reg_r - (INSTR_STEP2 ? 16'h0002 : 16'h0001);      // RQ8 RQ10
            end else if (apb_wr && PADDR == `OFS_LOOP_COUNT) begin
                loop_count_reg_r <= PWDATA[15:0];
            end
            if (apb_wr && PADDR == `OFS_CIRC_STEP) begin
                circular_step_reg_r <= PWDATA[15:0];
            end
            if (apb_wr && PADDR == `OFS_CTRL) begin
                tag_r <= PWDATA[`CTRL_TAG_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Program flow and interrupt holding
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            PC_LOAD     <= 1'b0;
            PC_TARGET   <= `RST_WORD;
            INSTR_DONE  <= 1'b0;
            IRQ_RELEASE <= 1'b0;
            loop_hold_r <= 1'b0;
        end else begin
            PC_LOAD     <= 1'b0;
            IRQ_RELEASE <= 1'b0;
            INSTR_DONE  <= corr_last || (take && op != dsp_exec_pkg::OP_CORRELATE && op != dsp_exec_pkg::OP_NONE);
            if (take && op == dsp_exec_pkg::OP_LOOP_OPEN) begin
                loop_hold_r <= 1'b1;
            end
            if (take && op == dsp_exec_pkg::OP_LOOP_CLOSE) begin
                // Single-cycle decision: the jump costs one cycle, not a full branch.
                PC_LOAD     <= 1'b1;                                                             // RQ12
                PC_TARGET   <= loop_count_reg_r[15] ? PC_IN + 16'h0001 : LOOP_START_PC;          // RQ8 RQ9
                loop_hold_r <= 1'b0;                                                             // RQ11
                IRQ_RELEASE <= 1'b1;                                                             // RQ11
            end
        end
    end

    // ------------------------------------------------------------
    // Accumulators, pointers and flags
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            for (int i = 0; i < 16; i++) begin
                acc_r[i] <= `RST_WORD;
            end
            for (int i = 0; i < 4; i++) begin
                acc_ptr_r[i] <= 4'h0;
            end
        end else begin
            if (apb_wr && PADDR >= `OFS_ACC_BASE && PADDR <= `OFS_ACC_LAST && PADDR[1:0] == 2'h0) begin
                acc_r[PADDR[5:2]] <= PWDATA[15:0];
            end
            if (apb_wr && PADDR == `OFS_ACC_PTR) begin
                for (int i = 0; i < 4; i++) begin
                    acc_ptr_r[i] <= PWDATA[4*i +: 4];
                end
            end
            if (corr_last) begin
                acc_r[corr_acc_r]        <= sum_nxt[15:0];                                       // RQ7
                acc_r[corr_acc_r + 4'h1] <= sum_nxt[31:16];                                      // RQ7
                acc_r[corr_acc_r + 4'h2] <= sum_nxt[47:32];                                      // RQ7
            end
            if (take && op == dsp_exec_pkg::OP_WORD_FILL) begin
                acc_ptr_r[INSTR_PTR_SEL] <= fill_ptr_nxt;                                        // RQ13
                acc_r[fill_ptr_nxt]      <= {16{sign_flag_r}};                                   // RQ14
            end
            // Runs once whatever the string count; the addressed word plus one is filled.
            if (take && op == dsp_exec_pkg::OP_STRING_FILL) begin
                acc_r[acc_ptr_r[INSTR_PTR_SEL] + 4'h1] <= {16{sign_flag_r}};                     // RQ15 RQ16
            end
        end
    end

    // Flags move only by software; the fill instructions leave them as they were.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            sign_flag_r  <= 1'b0;
            carry_flag_r <= 1'b0;
            zero_flag_r  <= 1'b0;
        end else if (apb_wr && PADDR == `OFS_STATUS) begin
            sign_flag_r  <= PWDATA[`STAT_SIGN_BIT];
            carry_flag_r <= PWDATA[`STAT_CARRY_BIT];
            zero_flag_r  <= PWDATA[`STAT_ZERO_BIT];
        end
    end

    // ------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (apb_setup) begin
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            if (PADDR >= `OFS_ACC_BASE && PADDR <= `OFS_ACC_LAST && PADDR[1:0] == 2'h0) begin
                PRDATA <= {16'h0000, acc_r[PADDR[5:2]]};
            end else begin
                unique case (PADDR)
                    `OFS_CTRL:       PRDATA <= {31'h0, tag_r};
                    `OFS_LOOP_COUNT: PRDATA <= {16'h0000, loop_count_reg_r};
                    `OFS_CIRC_STEP:  PRDATA <= {16'h0000, circular_step_reg_r};
                    `OFS_PTR_EVEN:   PRDATA <= {16'h0000, ptr_even_r};
                    `OFS_PTR_ODD:    PRDATA <= {16'h0000, ptr_odd_r};
                    `OFS_STATUS:     PRDATA <= {28'h0, zero_flag_r, carry_flag_r, sign_flag_r, !INSTR_READY};
                    `OFS_ACC_PTR:    PRDATA <= {16'h0000, acc_ptr_r[3], acc_ptr_r[2], acc_ptr_r[1], acc_ptr_r[0]};
                    default:         PSLVERR <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [15:0] busy_cnt_r;
    always_ff @(posedge CLOCK) begin
        if (RST || state_r == dsp_exec_pkg::ST_IDLE) begin
            busy_cnt_r <= 16'h0000;
        end else begin
            busy_cnt_r <= busy_cnt_r + 16'h0001;
        end
    end

    corr_length_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ2
        corr_last |-> (busy_cnt_r + 16'h0001) == 16'(`TAP_CYCLES * taps_r))
        else $error("correlation length is not three cycles per tap");

    tap_order_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ2
        state_r == dsp_exec_pkg::ST_ADDR |=> state_r == dsp_exec_pkg::ST_MULT ##1 state_r == dsp_exec_pkg::ST_ACC)
        else $error("tap does not run address, multiply, accumulate");

    irq_held_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ5
        state_r != dsp_exec_pkg::ST_IDLE |-> IRQ_HOLD)
        else $error("interrupts not held during correlation");

    circ_step_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ6
        (state_r == dsp_exec_pkg::ST_ACC && tag_r) |=> ptr_even_r == $past(ptr_even_r) + $past(circular_step_reg_r))
        else $error("circular step not added to even pointer");

    result_write_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ7
        corr_last |=> acc_r[$past(corr_acc_r) + 4'h2] == $past(sum_nxt[47:32]))
        else $error("upper result word not in third accumulator");

    loop_back_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ8
        (take && op == dsp_exec_pkg::OP_LOOP_CLOSE && !loop_count_reg_r[15])
        |=> PC_LOAD && PC_TARGET == $past(LOOP_START_PC)
            && loop_count_reg_r == $past(loop_count_reg_r) - ($past(INSTR_STEP2) ? 16'h0002 : 16'h0001))
        else $error("loop close did not jump back and decrement");

    loop_exit_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ9
        (take && op == dsp_exec_pkg::OP_LOOP_CLOSE && loop_count_reg_r[15])
        |=> PC_TARGET == $past(PC_IN) + 16'h0001 && IRQ_RELEASE)
        else $error("loop exit did not advance by one");

    word_fill_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ14
        (take && op == dsp_exec_pkg::OP_WORD_FILL)
        |=> acc_r[$past(fill_ptr_nxt)] == {16{sign_flag_r}} && $stable(carry_flag_r))
        else $error("word sign fill wrong");

    string_fill_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ15
        (take && op == dsp_exec_pkg::OP_STRING_FILL)
        |=> acc_r[$past(acc_ptr_r[INSTR_PTR_SEL]) + 4'h1] == {16{sign_flag_r}} && INSTR_DONE)
        else $error("string sign fill wrong");

    // Software may write STATUS in the same cycle; only the instruction itself is held to this.
    string_flags_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ16
        (take && op == dsp_exec_pkg::OP_STRING_FILL && !apb_wr)
        |=> $stable(carry_flag_r) && $stable(zero_flag_r))
        else $error("string sign fill changed carry or zero");

    premod_inc_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ13
        (take && op == dsp_exec_pkg::OP_WORD_FILL && INSTR_PREMOD == dsp_exec_pkg::PM_INC && !apb_wr)
        |=> acc_ptr_r[$past(INSTR_PTR_SEL)] == $past(acc_ptr_r[INSTR_PTR_SEL]) + 4'h1)
        else $error("accumulator pointer not pre-incremented");

    corr_run_c: cover property (@(posedge CLOCK) disable iff (RST) corr_last && tag_r);
    loop_back_c: cover property (@(posedge CLOCK) disable iff (RST) PC_LOAD && loop_hold_r == 1'b0);
    fill_c: cover property (@(posedge CLOCK) disable iff (RST) take && op == dsp_exec_pkg::OP_STRING_FILL);
    loop_exit_c: cover property (@(posedge CLOCK) disable iff (RST) PC_LOAD && IRQ_RELEASE && PC_TARGET != LOOP_START_PC);
    word_fill_c: cover property (@(posedge CLOCK) disable iff (RST) take && op == dsp_exec_pkg::OP_WORD_FILL);

endmodule : dsp_exec
`default_nettype wire

// >>> verilog/dsp_exec_consts.svh
// How it works
// RQ1: Repeated correlation multiplies data sample by program coefficient, accumulating to 48 bits.
// RQ2: Each tap takes three cycles; n taps take three times (repeat count plus two).
// RQ3: Software names an even pointer; the odd partner addresses the coefficient buffer.
// RQ4: Software issues correlation only as the target of a repeat instruction.
// RQ5: Interrupts stay pending while the repeated correlation runs.
// RQ6: Between taps add circular step when tag set, else post-increment if coded.
// RQ7: Result is written into three consecutive accumulators from the selected one.
// RQ8: Loop close with count zero or positive decrements it and jumps after loop open.
// RQ9: Loop close with negative count does nothing, advances PC by one, exits.
// RQ10: Loop close decrement step is 1 or 2, default 1.
// RQ11: Interrupts held since loop open are released at loop close, by priority.
// RQ12: Loop close adds only one cycle of overhead per iteration.
// RQ13: Word sign fill applies pointer pre-modification before writing the accumulator.
// RQ14: Word sign fill copies sign flag into all 16 bits; flags unchanged.
// RQ15: String sign fill targets the next accumulator with 16 copies of the sign.
// RQ16: String sign fill ignores string count, runs once, keeps carry and zero.
// RQ17: Software avoids string sign fill on all-zero strings, using word fill instead.
// RQ18: Tap count is repeat count plus two; interrupts masked from sequence start.
`ifndef DSP_EXEC_CONSTS_SVH
`define DSP_EXEC_CONSTS_SVH

`define OFS_CTRL       8'h00
`define OFS_LOOP_COUNT 8'h04
`define OFS_CIRC_STEP  8'h08
`define OFS_PTR_EVEN   8'h0c
`define OFS_PTR_ODD    8'h10
`define OFS_STATUS     8'h14
`define OFS_ACC_PTR    8'h18
`define OFS_ACC_BASE   8'h40
`define OFS_ACC_LAST   8'h7c

`define CTRL_TAG_BIT   0
`define STAT_BUSY_BIT  0
`define STAT_SIGN_BIT  1
`define STAT_CARRY_BIT 2
`define STAT_ZERO_BIT  3

`define RST_WORD       16'h0000
`define TAP_CYCLES     3
`define TAP_EXTRA      2

`endif

// >>> verilog/dsp_exec_pkg.sv
package dsp_exec_pkg;

    typedef enum logic [2:0] {
        OP_NONE        = 3'h0,
        OP_CORRELATE   = 3'h1,
        OP_LOOP_OPEN   = 3'h2,
        OP_LOOP_CLOSE  = 3'h3,
        OP_WORD_FILL   = 3'h4,
        OP_STRING_FILL = 3'h5
    } op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_MULT = 4'b0100,
        ST_ACC  = 4'b1000
    } corr_state_t;

    typedef enum logic [1:0] {
        PM_NONE = 2'h0,
        PM_INC  = 2'h1,
        PM_DEC  = 2'h2
    } premod_t;

endpackage : dsp_exec_pkg

// >>> test/mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// --------------------------------------------------------------------
// Program and data memory model
// --------------------------------------------------------------------
// Both memories are synchronous, so read data follows the address by one edge.
// The contents are address patterns that differ per word, so a wrong pointer shows up in the sum.
module mem_model (
    input  wire logic        clock,
    input  wire logic [15:0] dmem_addr,
    input  wire logic [15:0] pmem_addr,
    output var  logic [15:0] dmem_rdata,
    output var  logic [15:0] pmem_rdata
);
    always_ff @(posedge clock) begin
        dmem_rdata <= dmem_addr + 16'h0011;
        pmem_rdata <= pmem_addr ^ 16'h5a5a;
    end
endmodule : mem_model
`default_nettype wire

// >>> test/dsp_exec_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end

module dsp_exec_tb_top;
    logic        clock = 1'b0, rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0]  paddr = 8'h00, irpt = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        ivalid = 1'b0, iready, ipost = 1'b0, istep2 = 1'b0;
    logic [2:0]  iop = 3'h0;
    logic [1:0]  isel = 2'h0, ipremod = 2'h0;
    logic [15:0] pc_in = 16'h0040, loop_pc = 16'h0011, pc_target;
    logic [15:0] dmem_addr, dmem_rdata, pmem_addr, pmem_rdata;
    logic        pc_load, idone, irq_hold, irq_rel;
    int          mismatches = 0, check_count = 0;
    logic [15:0] lc_in  [4] = '{16'h0005, 16'h0000, 16'h8000, 16'h0001};
    logic [15:0] lc_exp [4] = '{16'h0003, 16'hffff, 16'h8000, 16'hffff};
    logic [3:0]  lc_st2 = 4'b1001;

    always #4 clock = ~clock;

    dsp_exec #(.RPT_W(8)) i_dsp_exec (
        .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .INSTR_VALID(ivalid), .INSTR_READY(iready), .INSTR_OP(iop), .INSTR_PTR_SEL(isel),
        .INSTR_POSTINC(ipost), .INSTR_STEP2(istep2), .INSTR_PREMOD(ipremod), .INSTR_REPEAT(irpt),
        .PC_IN(pc_in), .LOOP_START_PC(loop_pc), .DMEM_ADDR(dmem_addr), .DMEM_RDATA(dmem_rdata),
        .PMEM_ADDR(pmem_addr), .PMEM_RDATA(pmem_rdata), .PC_LOAD(pc_load), .PC_TARGET(pc_target),
        .INSTR_DONE(idone), .IRQ_HOLD(irq_hold), .IRQ_RELEASE(irq_rel));

    mem_model i_mem_model (.clock(clock), .dmem_addr(dmem_addr), .pmem_addr(pmem_addr),
        .dmem_rdata(dmem_rdata), .pmem_rdata(pmem_rdata));

    // --------------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------------
    // Every task starts on a fresh edge, so no signal is assigned twice in one time step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input string n);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK(n, x, q)
        `CHK("pslverr", 1'b0, e)
    endtask : rdchk

    function automatic logic [7:0] adr(input int idx);
        return 8'(64 + 4 * (idx % 16));
    endfunction : adr

    // Returns in the cycle after the taking edge, where single-cycle results stand.
    task automatic issue(input logic [2:0] op, input logic [1:0] sel, input logic post, st2,
                         input logic [1:0] pm, input logic [7:0] repeat_instr);
        @(posedge clock);
        ivalid <= 1'b1;
        iop <= op;
        isel <= sel;
        ipost <= post;
        istep2 <= st2;
        ipremod <= pm;
        irpt <= repeat_instr;
        do @(posedge clock); while (iready !== 1'b1);
        ivalid <= 1'b0;
        #1;
    endtask : issue

    task automatic corr(input logic [7:0] repeat_instr, input logic tag, post, input logic [15:0] stp,
                        input logic [1:0] sel, input int base);
        logic [47:0] y;
        logic [15:0] e, o;
        int          n;
        y = '0;
        e = 16'h0100;
        o = 16'h0200;
        for (int k = 0; k < repeat_instr + 2; k++) begin
            y = y + {32'h0, e + 16'h0011} * {32'h0, o ^ 16'h5a5a};
            e = e + (tag ? stp : {15'h0, post});
            o = o + 16'h0001;
        end
        wr(8'h00, {31'h0, tag});
        wr(8'h08, {16'h0, stp});
        wr(8'h0c, 32'h0100);
        wr(8'h10, 32'h0200);
        issue(dsp_exec_pkg::OP_CORRELATE, sel, post, 1'b0, dsp_exec_pkg::PM_NONE, repeat_instr);
        `CHK("irq_hold busy", 1'b1, irq_hold)
        `CHK("ready busy", 1'b0, iready)
        n = 0;
        while (idone !== 1'b1 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        `CHK("corr cycles", 3 * (repeat_instr + 2), n)
        rdchk(adr(base), {16'h0, y[15:0]}, "acc low");
        rdchk(adr(base + 1), {16'h0, y[31:16]}, "acc mid");
        rdchk(adr(base + 2), {16'h0, y[47:32]}, "acc high");
        rdchk(8'h0c, {16'h0, e}, "even ptr");
        rdchk(8'h10, {16'h0, o}, "odd ptr");
    endtask : corr

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    // --------------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic        e;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rdchk(8'h14, 32'h0, "status reset");
        rdchk(8'h04, 32'h0, "loop count reset");
        rdchk(8'h18, 32'h0, "acc ptr reset");
        apb(1'b0, 8'h20, 32'h0, q, e);
        `CHK("unmapped data", 32'h0, q)
        `CHK("unmapped err", 1'b1, e)
        $display("test reset done");

        wr(8'h18, 32'h3ae5);
        corr(8'h00, 1'b0, 1'b1, 16'h0000, 2'h0, 5);
        corr(8'h03, 1'b1, 1'b0, 16'h0003, 2'h1, 14);
        corr(8'h01, 1'b0, 1'b0, 16'h0000, 2'h2, 10);
        $display("test correlate done");

        for (int i = 0; i < 4; i++) begin
            wr(8'h04, {16'h0, lc_in[i]});
            issue(dsp_exec_pkg::OP_LOOP_OPEN, 2'h0, 1'b0, 1'b0, dsp_exec_pkg::PM_NONE, 8'h00);
            `CHK("irq_hold open", 1'b1, irq_hold)
            issue(dsp_exec_pkg::OP_LOOP_CLOSE, 2'h0, 1'b0, lc_st2[i], dsp_exec_pkg::PM_NONE, 8'h00);
            `CHK("pc_load", 1'b1, pc_load)
            `CHK("pc_target", (i == 2) ? 16'h0041 : 16'h0011, pc_target)
            `CHK("irq_release", 1'b1, irq_rel)
            `CHK("irq_hold close", 1'b0, irq_hold)
            @(posedge clock);
            #1;
            `CHK("pc_load pulse", 1'b0, pc_load)
            rdchk(8'h04, {16'h0, lc_exp[i]}, "loop count");
        end
        $display("test loop done");

        for (int i = 0; i < 2; i++) begin
            wr(8'h14, i ? 32'h8 : 32'h6);
            wr(adr(6 - i), i ? 32'hffff : 32'h0);
            issue(dsp_exec_pkg::OP_WORD_FILL, 2'h0, 1'b0, 1'b0,
                  i ? dsp_exec_pkg::PM_DEC : dsp_exec_pkg::PM_INC, 8'h00);
            `CHK("word done", 1'b1, idone)
            rdchk(8'h18, i ? 32'h3ae5 : 32'h3ae6, "acc ptr");
            rdchk(adr(6 - i), i ? 32'h0 : 32'hffff, "word fill");
            rdchk(8'h14, i ? 32'h8 : 32'h6, "status kept");
        end
        $display("test word fill done");

        wr(adr(3), 32'h1234);
        wr(adr(4), 32'h0);
        wr(8'h14, 32'h6);
        issue(dsp_exec_pkg::OP_STRING_FILL, 2'h3, 1'b0, 1'b0, dsp_exec_pkg::PM_NONE, 8'h05);
        `CHK("string done", 1'b1, idone)
        rdchk(adr(4), 32'hffff, "string fill");
        rdchk(adr(3), 32'h1234, "string source");
        rdchk(8'h14, 32'h6, "string status");
        $display("test string fill done");
        results();
    end

    initial begin
        #200000;
        mismatches++;
        results();
    end
endmodule : dsp_exec_tb_top
`default_nettype wire
